// [shared/srpl_pkg.sv]
// Constants shared by the supervisor reset and power-fail logic
package srpl_pkg;
  // Reference rate and documented times
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned RESET_HOLD_MS = 140;
  localparam int unsigned WDOG_TIMEOUT_MS = 1600;
  localparam int unsigned GLITCH_US = 25;
  localparam int unsigned STROBE_MIN_NS = 100;
  // Timebase tick period in ns and derived divider count
  localparam int unsigned TICK_NS = 1000;
  localparam int unsigned TICK_DIV = TICK_NS * CLK_HZ / 1_000_000_000;
  // Counts in timebase ticks (least times round up)
  localparam int unsigned RESET_HOLD_TICKS = RESET_HOLD_MS * 1000;
  localparam int unsigned WDOG_TICKS = WDOG_TIMEOUT_MS * 1000;
  localparam int unsigned GLITCH_TICKS = GLITCH_US;
  // Strobe pulse minimum in clock cycles
  localparam int unsigned STROBE_MIN_CYC =
    (STROBE_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned CNT_W = 24;
  localparam int unsigned SYNC_STAGES = 2;
  // Output structure per variant
  typedef enum logic {SRPL_PUSH_PULL, SRPL_OPEN_DRAIN} srpl_drive_t;
endpackage

// [hw/srpl_sync.sv]
// Two-flop synchroniser bank for asynchronous monitor inputs
`timescale 1ns/1ps
module srpl_sync #(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_reset_n,
  // Data
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  // Reset value is all zero; callers invert active-low pins
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= i_async;
      sync_ff <= meta_ff;
    end
  end

  assign o_sync = sync_ff;
endmodule

// [hw/srpl_top.sv]
// Supervisor reset and power-fail warning logic
`timescale 1ns/1ps
// Operation
// - Aux monitor below reference asserts processor reset.
// - Power-fail warning low while sense input below reference, else high.
// - Supply low disables power-fail compare and forces warning low.
// - Reset held while supply low, plus hold time after it clears.
// - Manual reset low asserts processor reset on variants having it.
// - Hold reset a further hold time after manual reset releases.
// - Watchdog timeout gives hold-length reset pulse, repeating while idle.
// - Outputs active low, push-pull or open-drain by build parameter.
// - Backup source loss with supply good causes no reset or backup.
// - Short supply-low glitches are filtered out.
// - Strobe edge, short pulse, or active reset clears watchdog.
// - Backup mode asserts both outputs and ignores other inputs.
module srpl_top #(
  parameter bit HAS_MANUAL = 1'b1,
  parameter bit HAS_WATCHDOG = 1'b1,
  parameter bit HAS_AUX = 1'b1,
  parameter srpl_pkg::srpl_drive_t DRIVE = srpl_pkg::SRPL_PUSH_PULL,
  parameter int unsigned TICK_DIV = srpl_pkg::TICK_DIV,
  parameter int unsigned RESET_HOLD_TICKS = srpl_pkg::RESET_HOLD_TICKS,
  parameter int unsigned WDOG_TICKS = srpl_pkg::WDOG_TICKS,
  parameter int unsigned GLITCH_TICKS = srpl_pkg::GLITCH_TICKS
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_reset_n,
  // Monitor flags, asynchronous
  input wire logic i_supply_low,
  input wire logic i_backup_mode,
  input wire logic i_aux_monitor_input,
  input wire logic i_powerfail_sense_input,
  // Pins, asynchronous
  input wire logic i_manual_reset_n,
  input wire logic i_watchdog_strobe,
  // Processor reset, active low
  output logic o_reset_n,
  output logic o_reset_oe_n,
  // Power-fail warning, active low
  output logic o_powerfail_warning_n,
  output logic o_powerfail_oe_n
);
  localparam int unsigned W = srpl_pkg::CNT_W;
  localparam int unsigned SMC = srpl_pkg::STROBE_MIN_CYC;

  initial begin
    if (TICK_DIV < 1 || TICK_DIV >= (1 << W) || RESET_HOLD_TICKS < 1 ||
        RESET_HOLD_TICKS >= (1 << W) || WDOG_TICKS < 1 ||
        WDOG_TICKS >= (1 << W) || GLITCH_TICKS >= (1 << W) || SMC >= 256)
      $error("srpl_top: count parameter out of range");
  end

  logic [5:0] raw;
  logic [5:0] syn;
  assign raw = {i_supply_low, i_backup_mode, i_aux_monitor_input,
                i_powerfail_sense_input, ~i_manual_reset_n,
                i_watchdog_strobe};
  srpl_sync #(.WIDTH(6)) u_sync (
    .i_mclk(i_mclk),
    .i_reset_n(i_reset_n),
    .i_async(raw),
    .o_sync(syn)
  );
  logic s_low, s_bkp, s_aux_low, s_pf_high, s_mr, s_wd;
  assign s_low = syn[5];
  assign s_bkp = syn[4];
  assign s_aux_low = ~syn[3];
  assign s_pf_high = syn[2];
  assign s_mr = syn[1] & HAS_MANUAL;
  assign s_wd = syn[0];

  logic [W-1:0] div_ff;
  logic tick_ff;
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      div_ff <= '0;
      tick_ff <= 1'b0;
    end else if (div_ff == W'(TICK_DIV - 1)) begin
      div_ff <= '0;
      tick_ff <= 1'b1;
    end else begin
      div_ff <= div_ff + 1'b1;
      tick_ff <= 1'b0;
    end
  end

  logic [W-1:0] glitch_ff;
  logic low_filt_ff;
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      glitch_ff <= '0;
      low_filt_ff <= 1'b1;
    end else if (!s_low) begin
      glitch_ff <= '0;
      low_filt_ff <= 1'b0;
    end else if (glitch_ff >= W'(GLITCH_TICKS)) begin
      low_filt_ff <= 1'b1;
    end else if (tick_ff) begin
      glitch_ff <= glitch_ff + 1'b1;
    end
  end

  // backup mode overrides; backup only counts with supply low
  logic backup;
  assign backup = s_bkp & low_filt_ff;

  // Strobe edge and short-pulse detector
  logic wd_prev_ff;
  logic [7:0] wd_stable_ff;
  logic wd_clear;
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      wd_prev_ff <= 1'b0;
      wd_stable_ff <= '0;
    end else begin
      wd_prev_ff <= s_wd;
      if (s_wd != wd_prev_ff)
        wd_stable_ff <= '0;
      else if (wd_stable_ff != 8'hFF)
        wd_stable_ff <= wd_stable_ff + 8'h01;
    end
  end
  // edge clears timer; pulses shorter than one clock period may be missed
  assign wd_clear = (s_wd != wd_prev_ff) && !backup;

  // Reset causes other than the watchdog
  logic cause;
  assign cause = low_filt_ff | backup |
                 (!backup & ((s_aux_low & HAS_AUX) | s_mr));

  logic [W-1:0] hold_ff;
  logic rst_ff;
  logic wd_fire;
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      hold_ff <= W'(RESET_HOLD_TICKS);
      rst_ff <= 1'b1;
    end else if (cause || wd_fire) begin
      hold_ff <= W'(RESET_HOLD_TICKS);
      rst_ff <= 1'b1;
    end else if (rst_ff) begin
      if (hold_ff == '0)
        rst_ff <= 1'b0;
      else if (tick_ff)
        hold_ff <= hold_ff - 1'b1;
    end
  end

  // watchdog timer, cleared by reset or strobe activity
  logic [W-1:0] wdog_ff;
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n || rst_ff || wd_clear || !HAS_WATCHDOG) begin
      wdog_ff <= '0;
    end else if (tick_ff && !wd_fire) begin
      wdog_ff <= wdog_ff + 1'b1;
    end
  end
  assign wd_fire = HAS_WATCHDOG && !rst_ff &&
                   (wdog_ff >= W'(WDOG_TICKS));

  logic pf_n_ff;
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n)
      pf_n_ff <= 1'b0;
    else
      pf_n_ff <= s_pf_high & !low_filt_ff & !backup;
  end

  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      o_reset_n <= 1'b0;
      o_reset_oe_n <= 1'b0;
      o_powerfail_warning_n <= 1'b0;
      o_powerfail_oe_n <= 1'b0;
    end else begin
      o_reset_n <= !rst_ff;
      o_powerfail_warning_n <= pf_n_ff;
      if (DRIVE == srpl_pkg::SRPL_OPEN_DRAIN) begin
        o_reset_oe_n <= !rst_ff;
        o_powerfail_oe_n <= pf_n_ff;
      end else begin
        o_reset_oe_n <= 1'b0;
        o_powerfail_oe_n <= 1'b0;
      end
    end
  end
endmodule

// [sim/srpl_top_asserts.sv]
// Port checks for the supervisor reset logic
`timescale 1ns/1ps
module srpl_top_asserts #(
  parameter srpl_pkg::srpl_drive_t DRIVE = srpl_pkg::SRPL_PUSH_PULL,
  parameter int unsigned TICK_DIV = 2,
  parameter int unsigned RESET_HOLD_TICKS = 10,
  parameter int unsigned WDOG_TICKS = 20
) (
  // Watched ports
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic i_supply_low,
  input wire logic i_aux_monitor_input,
  input wire logic i_powerfail_sense_input,
  input wire logic i_manual_reset_n,
  input wire logic i_watchdog_strobe,
  input wire logic o_reset_n,
  input wire logic o_reset_oe_n,
  input wire logic o_powerfail_warning_n,
  input wire logic o_powerfail_oe_n
);
  localparam int HOLD = RESET_HOLD_TICKS * TICK_DIV;
  localparam int WD = WDOG_TICKS * TICK_DIV;
  int quiet_ff = 0;
  int idle_ff = 0;
  logic wd_ff;
  wire logic cause = i_supply_low | !i_manual_reset_n | !i_aux_monitor_input;
  wire logic pf_ok = i_powerfail_sense_input & !i_supply_low;
  // Pin-level counts; slack covers synchroniser lag
  always_ff @(posedge i_mclk) begin
    wd_ff <= i_watchdog_strobe;
    quiet_ff <= cause ? 0 : quiet_ff + 1;
    idle_ff <= (!o_reset_n || wd_ff != i_watchdog_strobe) ? 0 : idle_ff + 1;
  end
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);
  property p_mr; !i_manual_reset_n [*6] |-> !o_reset_n; endproperty
  a_mr: assert property (p_mr) else $error("manual reset ignored");
  property p_aux; !i_aux_monitor_input [*6] |-> !o_reset_n; endproperty
  a_aux: assert property (p_aux) else $error("aux low ignored");
  property p_sup; i_supply_low [*8] ##1 i_supply_low [*4]
    |-> !o_reset_n && !o_powerfail_warning_n; endproperty
  a_sup: assert property (p_sup) else $error("supply low ignored");
  property p_pflo; !i_powerfail_sense_input [*6] |-> !o_powerfail_warning_n;
  endproperty
  a_pflo: assert property (p_pflo) else $error("warning not low");
  property p_pfhi; pf_ok [*8] ##1 pf_ok [*4] |-> o_powerfail_warning_n;
  endproperty
  a_pfhi: assert property (p_pfhi) else $error("warning not high");
  property p_hold; $rose(o_reset_n) |-> quiet_ff >= HOLD; endproperty
  a_hold: assert property (p_hold) else $error("hold too short");
  property p_wdfire; o_reset_n |-> idle_ff <= WD + 16; endproperty
  a_wdfire: assert property (p_wdfire) else $error("no timeout");
  property p_wdearly; $fell(o_reset_n) && quiet_ff > 30 |-> idle_ff + 8 >= WD;
  endproperty
  a_wdearly: assert property (p_wdearly) else $error("early");
  property p_oe; o_reset_oe_n == (DRIVE == srpl_pkg::SRPL_OPEN_DRAIN
    && o_reset_n); endproperty
  a_oe: assert property (p_oe) else $error("bad enable");
  property p_pfoe; o_powerfail_oe_n == (DRIVE == srpl_pkg::SRPL_OPEN_DRAIN
    && o_powerfail_warning_n); endproperty
  a_pfoe: assert property (p_pfoe) else $error("bad pf enable");
  c_wd: cover property ($fell(o_reset_n) && quiet_ff > 30);
  c_rel: cover property ($rose(o_reset_n));
  c_pf: cover property ($rose(o_powerfail_warning_n));
endmodule

// [sim/srpl_cpu_model.sv]
// Processor model kicking the watchdog from its loop
`timescale 1ns/1ps
module srpl_cpu_model #(
  parameter int KICK = 13
) (
  // Clock, reset pin, hang control, strobe
  input wire logic i_mclk,
  input wire logic i_cpu_reset_n,
  input wire logic i_hang,
  output logic o_strobe
);
  int cnt = 0;
  // low at start, toggled per loop
  always_ff @(posedge i_mclk) begin
    cnt <= (cnt == KICK) ? 0 : cnt + 1;
    if (i_cpu_reset_n !== 1'b1)
      o_strobe <= 1'b0;
    else if (!i_hang && cnt == KICK)
      o_strobe <= !o_strobe;
  end
endmodule

// [sim/srpl_top_tb.sv]
// Self-checking bench for the supervisor reset logic
`timescale 1ns/1ps
module srpl_top_tb;
  localparam int HOLD = 20;
  localparam int WD = 40;
  logic i_mclk = 1'b0, i_reset_n = 1'b0, sup = 1'b0, bkp = 1'b0;
  logic aux = 1'b1, pfs = 1'b1, mr_n = 1'b1, hang = 1'b0;
  wire logic stb, rst_n, oe_n, pf_n, pf_oe_n;
  int err_count = 0, checks = 0, n;
  logic [15:0] lf = 16'h5130;
  initial forever #2.5 i_mclk = ~i_mclk;
  srpl_top #(.DRIVE(srpl_pkg::SRPL_OPEN_DRAIN), .TICK_DIV(2),
    .RESET_HOLD_TICKS(10), .WDOG_TICKS(20), .GLITCH_TICKS(2)) uut (
    .i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_supply_low(sup),
    .i_backup_mode(bkp), .i_aux_monitor_input(aux),
    .i_powerfail_sense_input(pfs), .i_manual_reset_n(mr_n),
    .i_watchdog_strobe(stb), .o_reset_n(rst_n), .o_reset_oe_n(oe_n),
    .o_powerfail_warning_n(pf_n), .o_powerfail_oe_n(pf_oe_n));
  srpl_cpu_model cpu (.i_mclk(i_mclk), .i_cpu_reset_n(rst_n),
    .i_hang(hang), .o_strobe(stb));
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic cyc(input int k);
    repeat (k) @(posedge i_mclk);
    #1;
  endtask
  task automatic chk(input logic [1:0] got, input logic [1:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wait_lvl(input logic lvl, input int lim);
    n = 0;
    while (rst_n !== lvl && n < lim) begin
      cyc(1);
      n++;
    end
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    cyc(2);
    i_reset_n = 1'b1;
    wait_lvl(1'b1, 200);
    chk({n < 200, n >= HOLD}, 2'h3);
    for (int k = 0; k < 4; k++) begin
      {mr_n, aux, sup, bkp} = {k != 0, k != 1, k > 1, k == 3};
      cyc(14);
      chk({rst_n, pf_n}, {1'b0, k < 2});
      {mr_n, aux, sup, bkp} = 4'hC;
      wait_lvl(1'b1, 200);
      chk({n < 200, n >= HOLD}, 2'h3);
    end
    // One-cycle dip, well under the filter
    sup = 1'b1;
    cyc(1);
    sup = 1'b0;
    cyc(12);
    chk(2'(rst_n), 2'h1);
    // Backup flag with good supply must be ignored
    bkp = 1'b1;
    cyc(12);
    chk({rst_n, pf_n}, 2'h3);
    bkp = 1'b0;
    repeat (30) begin
      lf = lfsr(lf);
      pfs = lf[0];
      cyc(8);
      chk(2'(pf_n), 2'(pfs));
    end
    // Hung program gives repeated pulses
    hang = 1'b1;
    repeat (2) begin
      wait_lvl(1'b0, 200);
      chk({n < 200, n + 20 >= WD}, 2'h3);
      wait_lvl(1'b1, 200);
      chk({n < 200, n >= HOLD}, 2'h3);
    end
    hang = 1'b0;
    wait_lvl(1'b0, 150);
    chk(2'(n == 150), 2'h1);
    tally_and_finish();
  end
endmodule
bind srpl_top srpl_top_asserts #(.DRIVE(DRIVE), .TICK_DIV(TICK_DIV),
  .RESET_HOLD_TICKS(RESET_HOLD_TICKS), .WDOG_TICKS(WDOG_TICKS)) u_chk (
  .i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_supply_low(i_supply_low),
  .i_aux_monitor_input(i_aux_monitor_input),
  .i_powerfail_sense_input(i_powerfail_sense_input),
  .i_manual_reset_n(i_manual_reset_n),
  .i_watchdog_strobe(i_watchdog_strobe), .o_reset_n(o_reset_n),
  .o_reset_oe_n(o_reset_oe_n),
  .o_powerfail_warning_n(o_powerfail_warning_n),
  .o_powerfail_oe_n(o_powerfail_oe_n));
